/* hw/jpa_top.sv */
`timescale 1ns/1ps
`include "jpa_defines.svh"
// Contract
// RL1 - four-bit instruction register selects data path
// RL2 - all shift registers shift lsb first
// RL3 - port usable only with fuse and bit clear
// RL4 - external reset clears disable bit after two clocks
// RL5 - code 0xc selects reset chain, keeps tap
// RL6 - reset chain one resets core immediately
// RL7 - core stays in reset for time-out after
// RL8 - host resets core before entering programming
// RL9 - code 0x4 unlock compared at update
// RL10 - unlock register zero at power-on reset
// RL11 - code 0x5 fifteen-bit command shift register
// RL12 - capture loads previous command result
// RL13 - update applies command, idle issues clock
// RL14 - code 0x6 selects low byte register
// RL15 - page load writes byte within eleven clocks
// RL16 - page load alternates low then high bytes
// RL17 - counter pre-increments before low except first
// RL18 - code 0x7 captures alternating memory bytes
// RL19 - counter post-increments after every high read
// RL20 - host keeps test clock below core limit
// RL21 - signature mismatch keeps programming mode off
module jpa_top #(
  parameter int RESET_TIMEOUT_CYC = 16,  // core reset time-out, from clock fuses
  parameter int PC_WIDTH          = 16   // program counter width
) (
  // clock and reset
  input  wire logic                 I_CLOCK,
  input  wire logic                 I_ARST_N,
  // test pins
  input  wire logic                 I_TCK,
  input  wire logic                 I_TMS,
  input  wire logic                 I_TDI,
  output logic                      O_TDO,
  output logic                      O_TDO_OE_N,
  // device controls
  input  wire logic                 I_TEST_PORT_ENABLE_FUSE,
  input  wire logic                 I_EXT_RESET_N,
  input  wire logic                 I_DISABLE_SET,
  input  wire logic                 I_DISABLE_CLR,
  output logic                      O_TEST_PORT_DISABLE_BIT,
  output logic                      O_TEST_PORT_ACTIVE,
  output logic                      O_CORE_RESET,
  // memory side
  input  wire logic [14:0]          I_CMD_RESULT,
  input  wire logic [7:0]           I_MEM_LOW,
  input  wire logic [7:0]           I_MEM_HIGH,
  output logic [14:0]               O_CMD,
  output logic                      O_CMD_VALID,
  output logic                      O_CMD_CLOCK,
  output logic                      O_PROG_MODE,
  output logic [PC_WIDTH-1:0]       O_PC,
  output logic [7:0]                O_WR_DATA,
  output logic                      O_WR_LOW,
  output logic                      O_WR_HIGH
);
  localparam int TOW = $clog2(RESET_TIMEOUT_CYC + 1);
  localparam int LW  = $clog2(`JPA_LOAD_TCK_MAX + 1);

  typedef struct packed {
    logic [3:0]          ir;        // active instruction
    logic [3:0]          ir_sh;     // instruction shift path
    logic                rst_ch;    // reset chain bit
    logic [15:0]         unlock;    // unlock shift register
    logic [14:0]         cmd;       // command shift; low byte is data byte path
    logic                byp;       // bypass bit
    logic                prog;      // programming mode
    logic                dis;       // port disable bit
    logic [1:0]          dis_cnt;   // system clocks under external reset
    logic [1:0]          ext_s;     // external reset synchroniser
    logic [TOW-1:0]      tmo;       // reset time-out count
    logic [14:0]         cmd_out;   // applied command
    logic                cmd_vld;   // command applied
    logic                cmd_clk;   // execution clock pulse
    logic                hi;        // next byte is high byte
    logic                first;     // first byte since instruction selected
    logic [7:0]          hold;      // page-load holding byte
    logic                wr_pend;   // write pending
    logic                wr_hi;     // pending write is high byte
    logic [LW-1:0]       wr_cnt;    // write counter, cleared at update, never advanced
    logic                wr_lo_p;   // low write pulse
    logic                wr_hi_p;   // high write pulse
    logic [PC_WIDTH-1:0] pc;        // program counter
    logic                tdo;       // registered tdo
    logic                in_ir;     // open shift path is the instruction register
  } jpa_state_t;

  jpa_state_t s_q, s_d;
  jpa_tap_if  tap ();

  // pin sync and tap controller
  jpa_tap_ctrl u_tap (
    .i_clk   (I_CLOCK),
    .i_arst_n(I_ARST_N),
    .i_tck   (I_TCK),
    .i_tms   (I_TMS),
    .i_tdi   (I_TDI),
    .tap     (tap)
  );

  logic port_ok;   // test port usable
  logic ext_rst;   // synchronised external reset
  assign port_ok = I_TEST_PORT_ENABLE_FUSE & ~s_q.dis;  // [RL3]
  assign ext_rst = ~s_q.ext_s[1];

  // decoder for instruction membership
  function automatic logic is_ins(input logic [3:0] ir, input logic [3:0] code);
    return ir == code;
  endfunction

  // next state
  always_comb begin
    s_d         = s_q;
    s_d.ext_s   = {s_q.ext_s[0], I_EXT_RESET_N};
    s_d.cmd_clk = 1'b0;
    s_d.wr_lo_p = 1'b0;
    s_d.wr_hi_p = 1'b0;
    // disable bit: software set/clear, cleared under external reset
    if (I_DISABLE_SET) s_d.dis = 1'b1;
    else if (I_DISABLE_CLR) s_d.dis = 1'b0;
    if (ext_rst && s_q.dis) begin
      s_d.dis_cnt = s_q.dis_cnt + 2'h1;
      if (s_q.dis_cnt == 2'(`JPA_DISABLE_CLR_CYC - 1)) begin
        s_d.dis     = 1'b0;  // [RL4]
        s_d.dis_cnt = 2'h0;
      end
    end else begin
      s_d.dis_cnt = 2'h0;
    end
    // reset time-out after chain release
    if (s_q.rst_ch || ext_rst) s_d.tmo = TOW'(RESET_TIMEOUT_CYC);  // [RL7]
    else if (s_q.tmo != '0) s_d.tmo = s_q.tmo - TOW'(1);
    // shift-ir and shift-dr share one shift flag, so note which capture opened the path
    if (tap.cap_ir) s_d.in_ir = 1'b1;
    else if (tap.capture) s_d.in_ir = 1'b0;
    if (port_ok) begin
      // instruction path
      if (tap.cap_ir) s_d.ir_sh = 4'h1;
      if (tap.shift_ir) s_d.ir_sh = {tap.tdi, s_q.ir_sh[3:1]};  // [RL2]
      if (tap.upd_ir) begin
        s_d.ir    = s_q.ir_sh;  // [RL1]
        s_d.hi    = 1'b0;
        s_d.first = 1'b1;
      end
      // capture
      if (tap.capture) begin
        if (is_ins(s_q.ir, `JPA_INS_COMMAND)) s_d.cmd = I_CMD_RESULT;  // [RL12]
        if (is_ins(s_q.ir, `JPA_INS_PAGE_READ) && s_q.prog) begin
          s_d.cmd[7:0] = s_q.hi ? I_MEM_HIGH : I_MEM_LOW;  // [RL18]
          s_d.hi       = ~s_q.hi;
          if (s_q.hi) s_d.pc = s_q.pc + PC_WIDTH'(1);  // [RL19]
        end
        s_d.byp = 1'b0;
      end
      // shift, lsb first
      if (tap.shift) begin
        unique case (s_q.ir)
          `JPA_INS_RESET_CHAIN: s_d.rst_ch = tap.tdi;  // [RL5]
          `JPA_INS_UNLOCK:      s_d.unlock = {tap.tdi, s_q.unlock[15:1]};  // [RL2]
          `JPA_INS_COMMAND:     s_d.cmd = {tap.tdi, s_q.cmd[14:1]};  // [RL11]
          `JPA_INS_PAGE_LOAD,
          `JPA_INS_PAGE_READ:   s_d.cmd[7:0] = {tap.tdi, s_q.cmd[7:1]};  // [RL14]
          default:              s_d.byp = tap.tdi;
        endcase
      end
      // update
      if (tap.update) begin
        if (is_ins(s_q.ir, `JPA_INS_UNLOCK))
          s_d.prog = (s_q.unlock == `JPA_UNLOCK_SIG);  // [RL9] [RL21]
        if (is_ins(s_q.ir, `JPA_INS_COMMAND) && s_q.prog) begin
          s_d.cmd_out = s_q.cmd;  // [RL13]
          s_d.cmd_vld = 1'b1;
        end
        if (is_ins(s_q.ir, `JPA_INS_PAGE_LOAD) && s_q.prog) begin
          s_d.hold    = s_q.cmd[7:0];  // [RL15]
          s_d.wr_pend = 1'b1;
          s_d.wr_hi   = s_q.hi;  // [RL16]
          s_d.wr_cnt  = '0;
          s_d.hi      = ~s_q.hi;
          if (!s_q.hi && !s_q.first) s_d.pc = s_q.pc + PC_WIDTH'(1);  // [RL17]
          s_d.first   = 1'b0;
        end
      end
      // execution clock from run-test/idle
      if (tap.idle && s_q.cmd_vld && s_q.prog) s_d.cmd_clk = 1'b1;  // [RL13]
    end
    // page buffer write, issued on the next test clock rise (well within 11)
    if (s_q.wr_pend && tap.tck_rise) begin
      s_d.wr_pend = 1'b0;
      s_d.wr_lo_p = ~s_q.wr_hi;  // [RL15]
      s_d.wr_hi_p = s_q.wr_hi;
    end
    // tdo update on falling edge
    if (tap.tck_fall) begin
      if (tap.in_shift && s_q.in_ir) begin
        s_d.tdo = s_q.ir_sh[0];  // [RL2]
      end else begin
        unique case (1'b1)
          tap.in_shift && s_q.ir == `JPA_INS_RESET_CHAIN: s_d.tdo = s_q.rst_ch;
          tap.in_shift && s_q.ir == `JPA_INS_UNLOCK:      s_d.tdo = s_q.unlock[0];
          tap.in_shift && (s_q.ir == `JPA_INS_COMMAND || s_q.ir == `JPA_INS_PAGE_LOAD ||
                           s_q.ir == `JPA_INS_PAGE_READ): s_d.tdo = s_q.cmd[0];  // [RL2]
          default:                                         s_d.tdo = s_q.byp;
        endcase
      end
    end
    // leaving programming mode drops the applied command
    if (!s_q.prog) s_d.cmd_vld = 1'b0;
  end

  // state register
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s_q        <= '0;
      s_q.ir     <= `JPA_INS_BYPASS;
      s_q.unlock <= `JPA_UNLOCK_RESET;  // [RL10]
      s_q.first  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign O_TDO                   = s_q.tdo;
  assign O_TDO_OE_N              = ~(port_ok & tap.in_shift);
  assign O_TEST_PORT_DISABLE_BIT = s_q.dis;
  assign O_TEST_PORT_ACTIVE      = port_ok;
  assign O_CORE_RESET            = s_q.rst_ch | ext_rst | (s_q.tmo != '0);  // [RL6]
  assign O_CMD                   = s_q.cmd_out;
  assign O_CMD_VALID             = s_q.cmd_vld;
  assign O_CMD_CLOCK             = s_q.cmd_clk;
  assign O_PROG_MODE             = s_q.prog;
  assign O_PC                    = s_q.pc;
  assign O_WR_DATA               = s_q.hold;
  assign O_WR_LOW                = s_q.wr_lo_p;
  assign O_WR_HIGH               = s_q.wr_hi_p;

  // assertions
  property p_unlock_mismatch;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
    (tap.update && s_q.ir == `JPA_INS_UNLOCK && s_q.unlock != `JPA_UNLOCK_SIG && port_ok)
      |=> !O_PROG_MODE;
  endproperty
  a_unlock_mismatch: assert property (p_unlock_mismatch) // [RL21]
    else $error("prog mode entered on bad signature");

  property p_unlock_match;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
    (tap.update && s_q.ir == `JPA_INS_UNLOCK && s_q.unlock == `JPA_UNLOCK_SIG && port_ok)
      |=> O_PROG_MODE;
  endproperty
  a_unlock_match: assert property (p_unlock_match) // [RL9]
    else $error("prog mode not entered on good signature");

  property p_chain_reset;
    @(posedge I_CLOCK) disable iff (!I_ARST_N) s_q.rst_ch |-> O_CORE_RESET;
  endproperty
  a_chain_reset: assert property (p_chain_reset) // [RL6]
    else $error("core not in reset while chain holds one");

  property p_timeout;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
    $fell(s_q.rst_ch) && !ext_rst |-> O_CORE_RESET [*2];
  endproperty
  a_timeout: assert property (p_timeout) // [RL7]
    else $error("reset released without time-out");

  property p_dis_clear;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
    (ext_rst && s_q.dis && !I_DISABLE_SET && s_q.dis_cnt == 2'h0) ##1
      (ext_rst && !I_DISABLE_SET) |=> !O_TEST_PORT_DISABLE_BIT;
  endproperty
  a_dis_clear: assert property (p_dis_clear) // [RL4]
    else $error("disable bit not cleared after two clocks");

  property p_port_gate;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
    (!I_TEST_PORT_ENABLE_FUSE || s_q.dis) |-> O_TDO_OE_N;
  endproperty
  a_port_gate: assert property (p_port_gate) // [RL3]
    else $error("tdo driven while port disabled");

  sequence s_load_update;
    tap.update && s_q.ir == `JPA_INS_PAGE_LOAD && s_q.prog && port_ok;
  endsequence
  property p_load_write;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
    s_load_update |-> ##[1:240] (O_WR_LOW || O_WR_HIGH);
  endproperty
  a_load_write: assert property (p_load_write) // [RL15]
    else $error("page write not issued in time");

  property p_first_low;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
    s_load_update and s_q.first |=> !s_q.wr_hi && $stable(O_PC);
  endproperty
  a_first_low: assert property (p_first_low) // [RL16]
    else $error("first page-load byte not low or pc moved");

  property p_read_step;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
    (tap.capture && s_q.ir == `JPA_INS_PAGE_READ && s_q.prog && port_ok && s_q.hi)
      |=> O_PC == $past(O_PC) + PC_WIDTH'(1);
  endproperty
  a_read_step: assert property (p_read_step) // [RL19]
    else $error("pc not stepped after high read");
endmodule

/* common/jpa_defines.svh */
`ifndef JPA_DEFINES_SVH
`define JPA_DEFINES_SVH
// instruction codes
`define JPA_IR_WIDTH        4
`define JPA_INS_RESET_CHAIN 4'hc
`define JPA_INS_UNLOCK      4'h4
`define JPA_INS_COMMAND     4'h5
`define JPA_INS_PAGE_LOAD   4'h6
`define JPA_INS_PAGE_READ   4'h7
`define JPA_INS_BYPASS      4'hf
// data register widths
`define JPA_UNLOCK_WIDTH    16
`define JPA_CMD_WIDTH       15
`define JPA_BYTE_WIDTH      8
// unlock signature and reset value
`define JPA_UNLOCK_SIG      16'ha370
`define JPA_UNLOCK_RESET    16'h0000
// page-load write completes within this many test-clock cycles
`define JPA_LOAD_TCK_MAX    11
// system clocks before the disable bit is cleared under external reset
`define JPA_DISABLE_CLR_CYC 2
`endif

/* common/jpa_pkg.sv */
package jpa_pkg;
  // test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jpa_tap_t;
endpackage

/* common/jpa_tap_if.sv */
`timescale 1ns/1ps
// tap controller events seen by the main module
interface jpa_tap_if;
  logic tck_rise; // sampled test clock rising edge
  logic tck_fall; // sampled test clock falling edge
  logic tdi;      // synchronised test data in
  logic tms;      // synchronised mode select
  logic capture;  // capture-dr on this rising edge
  logic shift;    // shift-dr on this rising edge
  logic update;   // update-dr on this rising edge
  logic idle;     // run-test/idle on this rising edge
  logic cap_ir;   // capture-ir on this rising edge
  logic shift_ir; // shift-ir on this rising edge
  logic upd_ir;   // update-ir on this rising edge
  logic in_shift; // currently in a shift state (for tdo enable)
  modport ctrl (output tck_rise, tck_fall, tdi, tms, capture, shift, update, idle,
                output cap_ir, shift_ir, upd_ir, in_shift);
  modport user (input tck_rise, tck_fall, tdi, tms, capture, shift, update, idle,
                input cap_ir, shift_ir, upd_ir, in_shift);
endinterface

/* hw/jpa_tap_ctrl.sv */
`timescale 1ns/1ps
`include "jpa_defines.svh"
// pin synchroniser, edge finder and tap state machine
module jpa_tap_ctrl (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // test pins
  input  wire logic i_tck,
  input  wire logic i_tms,
  input  wire logic i_tdi,
  // events
  jpa_tap_if.ctrl   tap
);
  typedef struct packed {
    logic [2:0]      tck_s;  // [0] first stage, [1] second, [2] delayed copy
    logic [1:0]      tms_s;  // two-stage tms
    logic [1:0]      tdi_s;  // two-stage tdi
    jpa_pkg::jpa_tap_t st;   // controller state
  } jpa_tap_state_t;

  jpa_tap_state_t s_q, s_d;
  logic           rise;      // test clock rising edge

  assign rise = s_q.tck_s[1] & ~s_q.tck_s[2];

  // next state of synchronisers and controller
  always_comb begin
    s_d       = s_q;
    s_d.tck_s = {s_q.tck_s[1], s_q.tck_s[0], i_tck};
    s_d.tms_s = {s_q.tms_s[0], i_tms};
    s_d.tdi_s = {s_q.tdi_s[0], i_tdi};
    if (rise) begin
      unique case (s_q.st)
        jpa_pkg::TAP_RESET:    s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_RESET  : jpa_pkg::TAP_IDLE;
        jpa_pkg::TAP_IDLE:     s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_SEL_DR : jpa_pkg::TAP_IDLE;
        jpa_pkg::TAP_SEL_DR:   s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_SEL_IR : jpa_pkg::TAP_CAP_DR;
        jpa_pkg::TAP_CAP_DR:   s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_EXIT1_DR
                                                     : jpa_pkg::TAP_SHIFT_DR;
        jpa_pkg::TAP_SHIFT_DR: s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_EXIT1_DR
                                                     : jpa_pkg::TAP_SHIFT_DR;
        jpa_pkg::TAP_EXIT1_DR: s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_UPD_DR : jpa_pkg::TAP_PAUSE_DR;
        jpa_pkg::TAP_PAUSE_DR: s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_EXIT2_DR
                                                     : jpa_pkg::TAP_PAUSE_DR;
        jpa_pkg::TAP_EXIT2_DR: s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_UPD_DR
                                                     : jpa_pkg::TAP_SHIFT_DR;
        jpa_pkg::TAP_UPD_DR:   s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_SEL_DR : jpa_pkg::TAP_IDLE;
        jpa_pkg::TAP_SEL_IR:   s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_RESET  : jpa_pkg::TAP_CAP_IR;
        jpa_pkg::TAP_CAP_IR:   s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_EXIT1_IR
                                                     : jpa_pkg::TAP_SHIFT_IR;
        jpa_pkg::TAP_SHIFT_IR: s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_EXIT1_IR
                                                     : jpa_pkg::TAP_SHIFT_IR;
        jpa_pkg::TAP_EXIT1_IR: s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_UPD_IR : jpa_pkg::TAP_PAUSE_IR;
        jpa_pkg::TAP_PAUSE_IR: s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_EXIT2_IR
                                                     : jpa_pkg::TAP_PAUSE_IR;
        jpa_pkg::TAP_EXIT2_IR: s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_UPD_IR
                                                     : jpa_pkg::TAP_SHIFT_IR;
        jpa_pkg::TAP_UPD_IR:   s_d.st = s_q.tms_s[1] ? jpa_pkg::TAP_SEL_DR : jpa_pkg::TAP_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '{tck_s: 3'h0, tms_s: 2'h3, tdi_s: 2'h0, st: jpa_pkg::TAP_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  // events: actions of the current state happen on its rising edge
  assign tap.tck_rise = rise;
  assign tap.tck_fall = ~s_q.tck_s[1] & s_q.tck_s[2];
  assign tap.tdi      = s_q.tdi_s[1];
  assign tap.tms      = s_q.tms_s[1];
  assign tap.capture  = rise & (s_q.st == jpa_pkg::TAP_CAP_DR);
  assign tap.shift    = rise & (s_q.st == jpa_pkg::TAP_SHIFT_DR);
  assign tap.update   = rise & (s_q.st == jpa_pkg::TAP_UPD_DR);
  assign tap.idle     = rise & (s_q.st == jpa_pkg::TAP_IDLE);
  assign tap.cap_ir   = rise & (s_q.st == jpa_pkg::TAP_CAP_IR);
  assign tap.shift_ir = rise & (s_q.st == jpa_pkg::TAP_SHIFT_IR);
  assign tap.upd_ir   = rise & (s_q.st == jpa_pkg::TAP_UPD_IR);
  assign tap.in_shift = (s_q.st == jpa_pkg::TAP_SHIFT_DR) | (s_q.st == jpa_pkg::TAP_SHIFT_IR);
endmodule

/* verification/jpa_host_model.sv */
`timescale 1ns/1ps
// test-port host: drives the pins, parks the test clock low between frames
module jpa_host_model (
  // clock
  input  wire logic i_clk,
  // test data back from the device
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe_n,
  // test pins to the device
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  logic tdo_last; // last level seen while the device drove the line
  logic tdo_wire; // released line reads as the inverse of the last level
  assign tdo_wire = i_tdo_oe_n ? ~tdo_last : i_tdo;
  // idle levels at time zero
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    tdo_last = 1'b0;
  end
  // remember the driven level
  always @(posedge i_clk) begin
    if (i_tdo_oe_n === 1'b0) begin
      tdo_last <= i_tdo;
    end
  end
  // one 400 ns test clock, 2 high and 6 low, slow against the core clock
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_clk);
    tdo = tdo_wire;
    o_tms <= tms;
    o_tdi <= tdi;
    @(posedge i_clk);
    o_tck <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_tck <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  // from idle into a shift state, n bits, then update and back to idle
  task automatic scan(input logic ir, input logic [15:0] din, input int n,
                      output logic [15:0] dout);
    logic b;
    dout = 16'h0000;
    tick(1'b1, 1'b0, b);
    if (ir) begin
      tick(1'b1, 1'b0, b);
    end
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b); // lsb first both ways
      dout[i] = b;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask
  // load an instruction, return what capture-ir shifted out
  task automatic ir(input logic [3:0] code, output logic [3:0] cap);
    logic [15:0] d;
    scan(1'b1, {12'h000, code}, 4, d);
    cap = d[3:0];
  endtask
  // five ones reach test-logic-reset, then a zero to idle
  task automatic tap_reset();
    logic b;
    repeat (5) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
// self-checking bench for the programming test port
module tb_top;
  logic        clk, arst_n, tck, tms, tdi, tdo, tdo_oe_n;  // clock, reset, test pins
  logic        fuse, ext_n, dis_set, dis_clr, dis_bit;     // device controls
  logic        active, core_rst, cmd_valid, cmd_clk, prog; // status
  logic        wr_lo, wr_hi, wr_kind;                      // write strobes
  logic [14:0] cmd_res, cmd;                               // command path
  logic [7:0]  mem_lo, mem_hi, wr_data, wr_byte;           // byte paths
  logic [15:0] pc, wr_pc;                                  // program counter
  int          n_mismatch, n_checks, n_clk, n_wr;          // counters
  // device with a short reset time-out
  jpa_top #(.RESET_TIMEOUT_CYC(4), .PC_WIDTH(16)) i_dut (
    .I_CLOCK(clk), .I_ARST_N(arst_n), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
    .O_TDO(tdo), .O_TDO_OE_N(tdo_oe_n), .I_TEST_PORT_ENABLE_FUSE(fuse),
    .I_EXT_RESET_N(ext_n), .I_DISABLE_SET(dis_set), .I_DISABLE_CLR(dis_clr),
    .O_TEST_PORT_DISABLE_BIT(dis_bit), .O_TEST_PORT_ACTIVE(active),
    .O_CORE_RESET(core_rst), .I_CMD_RESULT(cmd_res), .I_MEM_LOW(mem_lo),
    .I_MEM_HIGH(mem_hi), .O_CMD(cmd), .O_CMD_VALID(cmd_valid), .O_CMD_CLOCK(cmd_clk),
    .O_PROG_MODE(prog), .O_PC(pc), .O_WR_DATA(wr_data), .O_WR_LOW(wr_lo),
    .O_WR_HIGH(wr_hi));
  // external host on the test pins
  jpa_host_model host (.i_clk(clk), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n),
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // counts execution clocks and records each page-buffer write
  always @(posedge clk) begin
    if (cmd_clk === 1'b1) begin
      n_clk <= n_clk + 1;
    end
    if (wr_lo === 1'b1 || wr_hi === 1'b1) begin
      n_wr <= n_wr + 1;
      wr_kind <= wr_hi;
      wr_byte <= wr_data;
      wr_pc <= pc;
    end
  end
  // verdict and end of run
  task automatic tally_and_finish();
    $display("TB: checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // disabled port refuses, external reset clears the disable bit
  task automatic t_disable();
    logic [3:0] c;
    logic [15:0] d;
    dis_set <= 1'b1;
    @(posedge clk);
    dis_set <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("port_active", 1'b0, active)
    host.ir(4'h4, c);
    host.scan(1'b0, 16'ha370, 16, d);
    `CHK("prog_refused", 1'b0, prog)
    ext_n <= 1'b0;
    @(posedge clk);
    `CHK("disable_early", 1'b1, dis_bit)
    repeat (7) @(posedge clk);
    `CHK("disable_cleared", 1'b0, dis_bit)
    `CHK("port_usable", 1'b1, active)
    ext_n <= 1'b1;
    repeat (10) @(posedge clk);
    host.tap_reset();
    $display("TEST t_disable done");
  endtask
  // reset chain selected, immediate reset, release after time-out
  task automatic t_chain();
    logic [3:0] c;
    logic [15:0] d;
    host.ir(4'hc, c);
    `CHK("ir_capture", 4'h1, c)
    host.scan(1'b0, 16'h0001, 1, d);
    `CHK("chain_reset", 1'b1, core_rst)
    host.scan(1'b0, 16'h0000, 1, d);
    `CHK("chain_kept", 1'b1, d[0])
    repeat (8) @(posedge clk);
    `CHK("reset_released", 1'b0, core_rst)
    host.scan(1'b0, 16'h0001, 1, d); // hold reset before programming
    $display("TEST t_chain done");
  endtask
  // wrong signature refused, right one enters programming mode
  task automatic t_unlock();
    logic [3:0] c;
    logic [15:0] d;
    host.ir(4'h4, c);
    host.scan(1'b0, 16'h0ec5, 16, d);
    `CHK("unlock_reset", 16'h0000, d)
    `CHK("prog_bad_sig", 1'b0, prog)
    host.ir(4'h5, c);
    host.scan(1'b0, 16'h1234, 15, d);
    `CHK("cmd_ignored", 1'b0, cmd_valid)
    host.ir(4'h4, c);
    host.scan(1'b0, 16'ha370, 16, d);
    `CHK("prog_entered", 1'b1, prog)
    $display("TEST t_unlock done");
  endtask
  // previous result out, new command applied, one clock per idle
  task automatic t_command();
    logic [3:0] c;
    logic [15:0] d;
    logic b;
    int k;
    cmd_res <= 15'h2b6d;
    host.ir(4'h5, c);
    host.scan(1'b0, 16'h1234, 15, d);
    `CHK("cmd_result", 15'h2b6d, d[14:0])
    `CHK("cmd_applied", 15'h1234, cmd)
    `CHK("cmd_valid", 1'b1, cmd_valid)
    k = n_clk;
    host.tick(1'b0, 1'b0, b);
    host.tick(1'b0, 1'b0, b);
    `CHK("exec_clocks", 2, n_clk - k)
    $display("TEST t_command done");
  endtask
  // four bytes: low, high, low, high, counter steps before second low
  task automatic t_load();
    logic [3:0] c;
    logic [15:0] d, p;
    logic b;
    int k;
    host.ir(4'h6, c);
    p = pc;
    for (int i = 0; i < 4; i++) begin
      k = n_wr;
      host.scan(1'b0, {8'h00, 8'ha1 + 8'(i)}, 8, d);
      host.tick(1'b0, 1'b0, b); // the write goes out on the next test clock rise
      `CHK("wr_count", k + 1, n_wr)
      `CHK("wr_high", i[0], wr_kind)
      `CHK("wr_data", 8'ha1 + 8'(i), wr_byte)
      `CHK("wr_pc", p + 16'(i / 2), wr_pc)
    end
    $display("TEST t_load done");
  endtask
  // four captures: low, high, low, high, counter steps after each high
  task automatic t_read();
    logic [3:0] c;
    logic [15:0] d, p;
    mem_lo <= 8'h3c;
    mem_hi <= 8'hc3;
    host.ir(4'h7, c);
    p = pc;
    for (int i = 0; i < 4; i++) begin
      host.scan(1'b0, 16'h0000, 8, d);
      `CHK("rd_byte", i[0] ? 8'hc3 : 8'h3c, d[7:0])
      `CHK("rd_pc", p + 16'((i + 1) / 2), pc)
    end
    host.ir(4'h4, c);
    host.scan(1'b0, 16'h0000, 16, d); // clear unlock on leaving
    `CHK("prog_left", 1'b0, prog)
    $display("TEST t_read done");
  endtask
  // main sequence
  initial begin
    {arst_n, dis_set, dis_clr, n_mismatch, n_checks, n_clk, n_wr} = '0;
    {fuse, ext_n, cmd_res, mem_lo, mem_hi} = {2'b11, 31'h0};
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    host.tap_reset();
    t_disable();
    t_chain();
    t_unlock();
    t_command();
    t_load();
    t_read();
    tally_and_finish();
  end
  // watchdog against a hung handshake
  initial begin
    #3000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
